// file: logic/dtc_timers.v
/*
 Wide 16-bit and narrow 8-bit up-counting timer/counters with an
 AXI4-Lite register slave and one level interrupt.
 Assumes a single clock aclk, a synchronous active-low reset and
 external pins asynchronous to aclk.
*/
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "dtc_defines.vh"

module dtc_timers (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // External pins
   input wire wide_clk_pin,
   input wire narrow_clk_pin,
   // Outputs
   output reg divider_out_n,
   output reg irq_q
);
   // Registers
   reg [1:0] wide_mode_q;
   reg wide_edge_select_q;
   reg wide_en_q;
   reg [7:0] wide_compare_low_q;
   reg [7:0] wide_compare_high_q;
   reg wide_cmp_hold_q;
   reg [15:0] wide_cnt_q;
   reg [1:0] narrow_mode_q;
   reg narrow_start_q;
   reg [7:0] narrow_compare_value_q;
   reg [7:0] narrow_active_q;
   reg [7:0] narrow_cnt_q;
   reg narrow_ff_q;
   reg [1:0] istat_q;
   reg [1:0] imask_q;
   reg wpin_d1_q;
   reg npin_d1_q;
   reg int_clk_d1_q;
   reg int_clk_q;
   // AXI holding state
   reg aw_held_q;
   reg w_held_q;
   reg [7:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;

   wire wpin_s;
   wire npin_s;

   // Pin synchronisers
   dtc_sync u_wsync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(wide_clk_pin),
      .level_q(wpin_s)
   );
   dtc_sync u_nsync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(narrow_clk_pin),
      .level_q(npin_s)
   );

   // Internal counting clock: aclk divided by two as an enable
   always @(posedge aclk) begin
      if (!aresetn) begin
         int_clk_q <= 1'b0;
         int_clk_d1_q <= 1'b0;
         wpin_d1_q <= 1'b0;
         npin_d1_q <= 1'b0;
      end else begin
         int_clk_q <= ~int_clk_q;
         int_clk_d1_q <= int_clk_q;
         wpin_d1_q <= wpin_s;
         npin_d1_q <= npin_s;
      end
   end

   wire int_rise = int_clk_q & ~int_clk_d1_q;
   wire wpin_rise = wpin_s & ~wpin_d1_q;
   wire wpin_fall = ~wpin_s & wpin_d1_q;
   wire npin_rise = npin_s & ~npin_d1_q;
   // Window gate: rising edge of internal clock AND window pin
   wire win_and = int_clk_q & wpin_s;
   wire win_and_d1 = int_clk_d1_q & wpin_d1_q;

   // Wide tick select per mode
   reg wide_tick;
   always @* begin
      case (wide_mode_q)
         `DTC_W_TIMER: wide_tick = int_rise;
         `DTC_W_COUNTER: wide_tick = wide_edge_select_q ?
            wpin_fall : wpin_rise;
         `DTC_W_WINDOW: wide_tick = win_and & ~win_and_d1;
         default: wide_tick = 1'b0;
      endcase
   end

   wire [15:0] wide_cmp = {wide_compare_high_q, wide_compare_low_q};
   // Matching suppressed between low and high writes
   wire wide_match = wide_en_q & ~wide_cmp_hold_q &
      (wide_cnt_q == wide_cmp);

   // Narrow tick select
   wire narrow_tick = (narrow_mode_q == `DTC_N_COUNTER) ?
      npin_rise : int_rise;
   wire narrow_pwm = (narrow_mode_q == `DTC_N_PWM);
   wire narrow_div = (narrow_mode_q == `DTC_N_DIVIDER);
   wire narrow_run = narrow_start_q;
   wire narrow_match = narrow_run & (narrow_cnt_q == narrow_active_q);
   wire narrow_ovf = narrow_run & narrow_tick &
      (narrow_cnt_q == `DTC_ONES8);
   // Narrow interrupt event
   wire narrow_evt = narrow_pwm ? narrow_ovf : narrow_match;
   wire wide_evt = wide_match;

   // AXI write decode
   wire wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
   wire wr_lo = wr_go & wstrb_q[0];
   wire wr_wctrl = wr_lo & (awaddr_q == `DTC_OFF_WCTRL);
   wire wr_wcmpl = wr_lo & (awaddr_q == `DTC_OFF_WCMPL);
   wire wr_wcmph = wr_lo & (awaddr_q == `DTC_OFF_WCMPH);
   wire wr_nctrl = wr_lo & (awaddr_q == `DTC_OFF_NCTRL);
   wire wr_ncmp = wr_lo & (awaddr_q == `DTC_OFF_NCMP);
   wire wr_imask = wr_lo & (awaddr_q == `DTC_OFF_IMASK);
   wire wr_known = (awaddr_q == `DTC_OFF_WCTRL) |
      (awaddr_q == `DTC_OFF_WCMPL) | (awaddr_q == `DTC_OFF_WCMPH) |
      (awaddr_q == `DTC_OFF_WCNT) | (awaddr_q == `DTC_OFF_NCTRL) |
      (awaddr_q == `DTC_OFF_NCMP) | (awaddr_q == `DTC_OFF_NCNT) |
      (awaddr_q == `DTC_OFF_ISTAT) | (awaddr_q == `DTC_OFF_IMASK);
   wire start_rise = wr_nctrl & wdata_q[`DTC_NC_START] & ~narrow_start_q;
   wire rd_go = s_axi_arvalid & s_axi_arready;
   wire rd_istat = rd_go & (s_axi_araddr == `DTC_OFF_ISTAT);

   // Wide configuration and compare registers
   always @(posedge aclk) begin
      if (!aresetn) begin
         wide_mode_q <= `DTC_W_TIMER;
         wide_edge_select_q <= 1'b0;
         wide_en_q <= 1'b0;
         wide_compare_low_q <= `DTC_CMP8_RST;
         wide_compare_high_q <= `DTC_CMP8_RST;
         wide_cmp_hold_q <= 1'b0;
      end else begin
         if (wr_wctrl) begin
            wide_mode_q <= wdata_q[`DTC_WC_MODE_LO +: 2];
            wide_edge_select_q <= wdata_q[`DTC_WC_EDGE];
            wide_en_q <= wdata_q[`DTC_WC_EN];
         end
         if (wr_wcmpl) begin
            wide_compare_low_q <= wdata_q[7:0];
            wide_cmp_hold_q <= 1'b1;
         end
         if (wr_wcmph) begin
            wide_compare_high_q <= wdata_q[7:0];
            wide_cmp_hold_q <= 1'b0;
         end
      end
   end

   // Wide counter: 16-bit up count, clear on match
   always @(posedge aclk) begin
      if (!aresetn) begin
         wide_cnt_q <= `DTC_ZERO16;
      end else if (!wide_en_q) begin
         wide_cnt_q <= `DTC_ZERO16;
      end else if (wide_match) begin
         wide_cnt_q <= `DTC_ZERO16;
      end else if (wide_tick) begin
         wide_cnt_q <= wide_cnt_q + `DTC_ONE16;
      end
   end

   // Narrow control and compare, double-buffered in PWM mode only
   always @(posedge aclk) begin
      if (!aresetn) begin
         narrow_mode_q <= `DTC_N_TIMER;
         narrow_start_q <= 1'b0;
         narrow_compare_value_q <= `DTC_CMP8_RST;
         narrow_active_q <= `DTC_CMP8_RST;
      end else begin
         if (wr_nctrl) begin
            narrow_mode_q <= wdata_q[`DTC_NC_MODE_LO +: 2];
            narrow_start_q <= wdata_q[`DTC_NC_START];
         end
         if (wr_ncmp) begin
            narrow_compare_value_q <= wdata_q[7:0];
         end
         if (start_rise) begin
            narrow_active_q <= narrow_compare_value_q;
         end else if (narrow_pwm) begin
            if (narrow_ovf) begin
               narrow_active_q <= narrow_compare_value_q;
            end
         end else if (wr_ncmp) begin
            narrow_active_q <= wdata_q[7:0];
         end
      end
   end

   // Narrow counter: 8-bit, wraps in PWM, clears on match otherwise
   always @(posedge aclk) begin
      if (!aresetn) begin
         narrow_cnt_q <= `DTC_ZERO8;
      end else if (!narrow_run) begin
         narrow_cnt_q <= `DTC_ZERO8;
      end else if (narrow_pwm) begin
         if (narrow_tick) begin
            narrow_cnt_q <= narrow_cnt_q + `DTC_ONE8;
         end
      end else if (narrow_match) begin
         narrow_cnt_q <= `DTC_ZERO8;
      end else if (narrow_tick) begin
         narrow_cnt_q <= narrow_cnt_q + `DTC_ONE8;
      end
   end

   // Output flip-flop: reset zero, software preset, toggles
   always @(posedge aclk) begin
      if (!aresetn) begin
         narrow_ff_q <= 1'b0;
      end else if (wr_nctrl & wdata_q[`DTC_NC_FFSET]) begin
         narrow_ff_q <= wdata_q[`DTC_NC_FFVAL];
      end else if (narrow_div & narrow_match) begin
         narrow_ff_q <= ~narrow_ff_q;
      end else if (narrow_pwm & (narrow_ovf |
         (narrow_match & narrow_tick))) begin
         narrow_ff_q <= ~narrow_ff_q;
      end
   end

   // Output pin driven from a flop, inverted flip-flop value
   always @(posedge aclk) begin
      if (!aresetn) begin
         divider_out_n <= 1'b1;
      end else begin
         divider_out_n <= ~narrow_ff_q;
      end
   end

   // Sticky status, set wins over read-clear; level interrupt
   always @(posedge aclk) begin
      if (!aresetn) begin
         istat_q <= 2'h0;
         imask_q <= 2'h0;
         irq_q <= 1'b0;
      end else begin
         istat_q[`DTC_IRQ_WIDE] <= wide_evt |
            (istat_q[`DTC_IRQ_WIDE] & ~rd_istat);
         istat_q[`DTC_IRQ_NARROW] <= (narrow_evt & narrow_run) |
            (istat_q[`DTC_IRQ_NARROW] & ~rd_istat);
         if (wr_imask) begin
            imask_q <= wdata_q[1:0];
         end
         irq_q <= |(istat_q & imask_q);
      end
   end

   // AXI write channel: address and data in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `DTC_RESP_OKAY;
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
      end else begin
         s_axi_awready <= ~aw_held_q & ~s_axi_awready & ~s_axi_bvalid;
         s_axi_wready <= ~w_held_q & ~s_axi_wready & ~s_axi_bvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read data mux
   reg [31:0] rd_d;
   reg rd_ok;
   always @* begin
      rd_d = 32'h00000000;
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `DTC_OFF_WCTRL: rd_d[3:0] = {wide_en_q, wide_edge_select_q,
            wide_mode_q};
         `DTC_OFF_WCMPL: rd_d[7:0] = wide_compare_low_q;
         `DTC_OFF_WCMPH: rd_d[7:0] = wide_compare_high_q;
         `DTC_OFF_WCNT: rd_d[15:0] = wide_cnt_q;
         `DTC_OFF_NCTRL: rd_d[4:0] = {narrow_ff_q, 1'b0, narrow_start_q,
            narrow_mode_q};
         `DTC_OFF_NCMP: rd_d[7:0] = narrow_compare_value_q;
         `DTC_OFF_NCNT: rd_d[7:0] = narrow_cnt_q;
         `DTC_OFF_ISTAT: rd_d[1:0] = istat_q;
         `DTC_OFF_IMASK: rd_d[1:0] = imask_q;
         default: rd_ok = 1'b0;
      endcase
   end

   // AXI read channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `DTC_RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_d;
            s_axi_rresp <= rd_ok ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// file: logic/dtc_defines.vh
/*
 Constants for the dual timer/counter block: register offsets, field
 positions, mode codes and reset values.
 Assumes inclusion by bare name from the design files.
*/
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH

// Register byte offsets
`define DTC_OFF_WCTRL 8'h00
`define DTC_OFF_WCMPL 8'h04
`define DTC_OFF_WCMPH 8'h08
`define DTC_OFF_WCNT 8'h0c
`define DTC_OFF_NCTRL 8'h10
`define DTC_OFF_NCMP 8'h14
`define DTC_OFF_NCNT 8'h18
`define DTC_OFF_ISTAT 8'h1c
`define DTC_OFF_IMASK 8'h20

// Wide control fields
`define DTC_WC_MODE_LO 0
`define DTC_WC_EDGE 2
`define DTC_WC_EN 3
// Narrow control fields
`define DTC_NC_MODE_LO 0
`define DTC_NC_START 2
`define DTC_NC_FFSET 3
`define DTC_NC_FFVAL 4

// Mode codes
`define DTC_W_TIMER 2'h0
`define DTC_W_COUNTER 2'h1
`define DTC_W_WINDOW 2'h2
`define DTC_N_TIMER 2'h0
`define DTC_N_COUNTER 2'h1
`define DTC_N_DIVIDER 2'h2
`define DTC_N_PWM 2'h3

// Interrupt status bits
`define DTC_IRQ_WIDE 0
`define DTC_IRQ_NARROW 1

// Reset values and constants
`define DTC_ZERO16 16'h0000
`define DTC_ZERO8 8'h00
`define DTC_ONES8 8'hff
`define DTC_CMP16_RST 16'hffff
`define DTC_CMP8_RST 8'hff
`define DTC_ONE16 16'h0001
`define DTC_ONE8 8'h01
`define DTC_RESP_OKAY 2'h0
`define DTC_RESP_SLVERR 2'h2

`endif

// file: logic/dtc_sync.v
/*
 Two flip-flop synchroniser for one pin level.
 Assumes the pin is asynchronous to aclk.
*/
`timescale 1ns/10ps
module dtc_sync (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Pin in, level out
   input wire pin,
   output reg level_q
);
   reg meta_q;

   // First stage feeds only the second
   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= 1'b0;
         level_q <= 1'b0;
      end else begin
         meta_q <= pin;
         level_q <= meta_q;
      end
   end
endmodule

// file: tb/dtc_props.sv
/*
 Checker on the dtc_timers ports: bus handshakes and reset state.
 Assumes one clock aclk and a synchronous active-low aresetn.
*/
`timescale 1ns/10ps
module dtc_props (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Write handshakes
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   // Read handshakes
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // Outputs
   input wire divider_out_n,
   input wire irq_q
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Transfer steps
   sequence s_rd_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence

   a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   a_rd_cause: assert property ($rose(s_axi_rvalid) |->
      $past(s_axi_arvalid) && $past(s_axi_arready))
      else $error("read data without a taken address");
   // Both halves are held one cycle before the response rises
   a_wr_answer: assert property (s_wr_take |=> ##1 s_axi_bvalid)
      else $error("write not answered two cycles after take");
   a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read response repeated");
   // Idle ready toggles, so it is checked as a pulse only
   a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("address ready not a single pulse");
   a_reset_out: assert property (disable iff (1'b0)
      !aresetn |=> divider_out_n && !irq_q)
      else $error("outputs not idle after reset");
   a_div_step: assert property (
      $changed(divider_out_n) |=> $stable(divider_out_n))
      else $error("divider output changed on adjacent cycles");
endmodule

bind dtc_timers dtc_props u_props (.*);

// file: tb/dtc_pin_src.sv
/*
 Source model for the two external pins of dtc_timers.
 Assumes the pins are synchronised to aclk inside the timers.
*/
`timescale 1ns/10ps
module dtc_pin_src (
   // Clock
   input wire aclk,
   // Pins toward the timers
   output logic wide_clk_pin,
   output logic narrow_clk_pin
);
   // Pins idle low
   initial begin
      wide_clk_pin = 1'b0;
      narrow_clk_pin = 1'b0;
   end
   // Wide pin level, changed just after an edge
   task wlev(input logic v);
      @(posedge aclk);
      wide_clk_pin <= v;
   endtask
   // Window pin held high for n+1 cycles, then low
   task wwin(input int n);
      wlev(1'b1);
      repeat (n) @(posedge aclk);
      wlev(1'b0);
      // Keep the pin low two cycles before another window
      @(posedge aclk);
   endtask
   // Narrow pin pulses, two cycles high and two low
   task npulse(input int n);
      repeat (n) begin
         @(posedge aclk);
         narrow_clk_pin <= 1'b1;
         repeat (2) @(posedge aclk);
         narrow_clk_pin <= 1'b0;
         @(posedge aclk);
      end
   endtask
endmodule

// file: tb/dtc_timers_tb_top.sv
/*
 Bench for dtc_timers: bus tasks, timer scenarios and verdict.
 Assumes dtc_pin_src drives the two external pins.
*/
`timescale 1ns/10ps
`include "dtc_defines.vh"
module dtc_timers_tb_top;
   logic aclk = 0;
   logic aresetn = 0;
   logic [7:0] awaddr = 0;
   logic [7:0] araddr = 0;
   logic [31:0] wdata = 0;
   logic [31:0] rv;
   logic [1:0] rr;
   logic awvalid = 0;
   logic wvalid = 0;
   logic arvalid = 0;
   logic bready = 0;
   logic rready = 0;
   logic [3:0] wstrb = 4'hf;
   wire awready, wready, bvalid, arready, rvalid, wpin, npin, div_n, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int num_errors = 0, n_compared = 0, cyc = 0, t0, a, b, h1, h2;

   always #20 aclk = ~aclk;

   dtc_pin_src PIN (.aclk(aclk), .wide_clk_pin(wpin),
      .narrow_clk_pin(npin));
   dtc_timers DUT (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .wide_clk_pin(wpin), .narrow_clk_pin(npin),
      .divider_out_n(div_n), .irq_q(irq));

   task summarize;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input [31:0] g, input [31:0] e);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   // Bus write, offered together, held until taken
   task wr(input [7:0] ad, input [31:0] d, input [1:0] e = 2'h0);
      awaddr <= ad;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!bvalid);
      bready <= 0;
      chk(bresp, e);
      // One idle edge before the next request
      @(posedge aclk);
   endtask
   task rd(input [7:0] ad);
      araddr <= ad;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
      end while (!rvalid);
      rv = rdata;
      rr = rresp;
      rready <= 0;
      @(posedge aclk);
   endtask
   task rc(input [7:0] ad, input [31:0] e);
      rd(ad);
      chk(rv, e);
   endtask
   task wt(input logic v);
      while (div_n !== v) @(posedge aclk);
   endtask
   // One divider half period, second half compared to first
   task hp(output int h);
      wt(1);
      wt(0);
      t0 = cyc;
      wt(1);
      h = cyc - t0;
      t0 = cyc;
      wt(0);
      chk(cyc - t0, h);
   endtask

   // Cycle count for timestamps and hang limit
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         num_errors++;
         summarize;
      end
   end

   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      chk(div_n, 1);
      chk(irq, 0);
      @(posedge aclk);
      rc(`DTC_OFF_WCMPL, 32'hff);
      rc(8'h40, 0);
      chk(rr, `DTC_RESP_SLVERR);
      wr(8'h40, 1, `DTC_RESP_SLVERR);
      // Low byte lane off: write accepted but ignored
      wstrb <= 4'h0;
      wr(`DTC_OFF_WCMPL, 8'h12);
      wstrb <= 4'hf;
      rc(`DTC_OFF_WCMPL, 32'hff);
      $display("reset test done");
      // Wide timer, suppressed match, 16-bit count
      wr(`DTC_OFF_IMASK, 3);
      wr(`DTC_OFF_WCMPL, 5);
      wr(`DTC_OFF_WCMPH, 0);
      wr(`DTC_OFF_WCTRL, 8);
      repeat (30) @(posedge aclk);
      chk(irq, 1);
      rd(`DTC_OFF_WCNT);
      chk(rv <= 5, 1);
      wr(`DTC_OFF_WCMPL, 7);
      rd(`DTC_OFF_ISTAT);
      repeat (40) @(posedge aclk);
      rc(`DTC_OFF_ISTAT, 0);
      wr(`DTC_OFF_WCMPH, 1);
      wr(`DTC_OFF_WCTRL, 0);
      wr(`DTC_OFF_WCTRL, 8);
      repeat (512) @(posedge aclk);
      rd(`DTC_OFF_WCNT);
      chk(rv > 255, 1);
      rc(`DTC_OFF_ISTAT, 0);
      repeat (30) @(posedge aclk);
      rc(`DTC_OFF_ISTAT, 1);
      $display("wide timer test done");
      // Wide counter on either pin edge
      wr(`DTC_OFF_WCMPL, 3);
      wr(`DTC_OFF_WCMPH, 0);
      for (int e = 0; e < 2; e++) begin
         wr(`DTC_OFF_WCTRL, 0);
         wr(`DTC_OFF_WCTRL, 9 | (e << 2));
         PIN.wlev(1);
         repeat (6) @(posedge aclk);
         rc(`DTC_OFF_WCNT, e ? 0 : 1);
         PIN.wlev(0);
         repeat (6) @(posedge aclk);
         rc(`DTC_OFF_WCNT, 1);
      end
      rd(`DTC_OFF_ISTAT);
      repeat (2) PIN.wwin(3);
      repeat (6) @(posedge aclk);
      rc(`DTC_OFF_ISTAT, 1);
      rc(`DTC_OFF_WCNT, 0);
      // Window mode counts only inside the window
      wr(`DTC_OFF_WCMPL, 8'hff);
      wr(`DTC_OFF_WCMPH, 0);
      wr(`DTC_OFF_WCTRL, 0);
      wr(`DTC_OFF_WCTRL, 8'ha);
      repeat (10) @(posedge aclk);
      rc(`DTC_OFF_WCNT, 0);
      PIN.wwin(20);
      repeat (6) @(posedge aclk);
      rd(`DTC_OFF_WCNT);
      chk(rv >= 9 && rv <= 11, 1);
      wr(`DTC_OFF_WCTRL, 0);
      $display("wide counter test done");
      // Narrow timer, masked then unmasked
      wr(`DTC_OFF_IMASK, 0);
      rd(`DTC_OFF_ISTAT);
      wr(`DTC_OFF_NCMP, 4);
      wr(`DTC_OFF_NCTRL, 4);
      repeat (30) @(posedge aclk);
      chk(irq, 0);
      rc(`DTC_OFF_ISTAT, 2);
      rd(`DTC_OFF_NCNT);
      chk(rv <= 4, 1);
      wr(`DTC_OFF_IMASK, 2);
      repeat (12) @(posedge aclk);
      chk(irq, 1);
      wr(`DTC_OFF_NCTRL, 0);
      rd(`DTC_OFF_ISTAT);
      repeat (2) @(posedge aclk);
      chk(irq, 0);
      // Narrow counter on pin pulses
      wr(`DTC_OFF_NCMP, 2);
      wr(`DTC_OFF_NCTRL, 5);
      PIN.npulse(1);
      repeat (6) @(posedge aclk);
      rc(`DTC_OFF_NCNT, 1);
      PIN.npulse(1);
      repeat (6) @(posedge aclk);
      rc(`DTC_OFF_NCNT, 0);
      rc(`DTC_OFF_ISTAT, 2);
      $display("narrow counter test done");
      // Divider: loaded flip-flop, half periods, interrupts
      wr(`DTC_OFF_NCTRL, 0);
      wr(`DTC_OFF_NCMP, 3);
      wr(`DTC_OFF_NCTRL, 8'h1a);
      repeat (2) @(posedge aclk);
      chk(div_n, 0);
      rd(`DTC_OFF_NCTRL);
      chk(rv[4], 1);
      wr(`DTC_OFF_NCTRL, 8'h0e);
      hp(h1);
      wr(`DTC_OFF_NCMP, 7);
      hp(h2);
      chk(h2 - h1, 8);
      rd(`DTC_OFF_ISTAT);
      wt(1);
      repeat (3) @(posedge aclk);
      rc(`DTC_OFF_ISTAT, 2);
      $display("divider test done");
      // Pulse width: staged compare, overflow interrupt
      wr(`DTC_OFF_NCTRL, 8'h0b);
      wr(`DTC_OFF_NCMP, 8'h40);
      wr(`DTC_OFF_NCTRL, 7);
      wt(0);
      t0 = cyc;
      rd(`DTC_OFF_ISTAT);
      wt(1);
      a = cyc - t0;
      t0 = cyc;
      wr(`DTC_OFF_NCMP, 8'h80);
      rc(`DTC_OFF_ISTAT, 2);
      wt(0);
      b = cyc - t0;
      chk(a + b, 512);
      wt(1);
      t0 = cyc;
      wt(0);
      chk(cyc - t0, b + 128);
      $display("pulse width test done");
      summarize;
   end
endmodule
